// ===== hdl/line_state_pkg.sv
/*
 package for the line state detector: register map, field positions,
 reset values, threshold limits, hysteresis ratio and carrier types.
 assumes a 32-bit classic wishbone register bus and a front end that
 delivers unsigned fundamental magnitudes on the same clock.
*/
package line_state_pkg;

   localparam int MAG_W = 16;
   localparam int PCT_W = 7;
   localparam int ADR_W = 5;
   localparam int IRQ_W = 4;

   // register byte offsets
   localparam logic [ADR_W-1:0] REG_CTRL = 5'h00;
   localparam logic [ADR_W-1:0] REG_VOLT_THR = 5'h04;
   localparam logic [ADR_W-1:0] REG_CURR_THR = 5'h08;
   localparam logic [ADR_W-1:0] REG_FLAGS = 5'h0C;
   localparam logic [ADR_W-1:0] REG_IRQ_STAT = 5'h10;
   localparam logic [ADR_W-1:0] REG_IRQ_CLR = 5'h14;
   localparam logic [ADR_W-1:0] REG_IRQ_EN = 5'h18;

   // control field
   localparam int CTRL_OPERATION_BIT = 0;
   localparam logic CTRL_OPERATION_RST = 1'b0;

   // flags register fields
   localparam int FLAGS_VOLT_LSB = 0;
   localparam int FLAGS_CURR_LSB = 3;
   localparam int FLAGS_DEAD_BIT = 6;
   localparam int FLAGS_LIVE_BIT = 7;
   localparam int FLAGS_BLOCK_BIT = 8;

   // interrupt status bits
   localparam int IRQ_DEAD_RISE = 0;
   localparam int IRQ_DEAD_FALL = 1;
   localparam int IRQ_LIVE_RISE = 2;
   localparam int IRQ_LIVE_FALL = 3;

   // thresholds in percent of nominal
   localparam logic [PCT_W-1:0] VOLT_THR_MIN = 7'd10;
   localparam logic [PCT_W-1:0] VOLT_THR_MAX = 7'd100;
   localparam logic [PCT_W-1:0] VOLT_THR_RST = 7'd60;
   localparam logic [PCT_W-1:0] CURR_THR_MIN = 7'd2;
   localparam logic [PCT_W-1:0] CURR_THR_MAX = 7'd100;
   localparam logic [PCT_W-1:0] CURR_THR_RST = 7'd10;

   // drop-off at 0.95 of pick-up
   localparam logic [31:0] PCT_SCALE = 32'h0000_0064;
   localparam logic [31:0] HYST_NUM = 32'h0000_0013;
   localparam logic [31:0] HYST_DEN = 32'h0000_0014;

   typedef struct packed {
      logic [MAG_W-1:0] phase1VoltageFundamental;
      logic [MAG_W-1:0] phase2VoltageFundamental;
      logic [MAG_W-1:0] phase3VoltageFundamental;
      logic [MAG_W-1:0] phase1CurrentFundamental;
      logic [MAG_W-1:0] phase2CurrentFundamental;
      logic [MAG_W-1:0] phase3CurrentFundamental;
   } phase_fund_s;

   typedef enum logic [3:0] {
      LS_OFF = 4'b0001,
      LS_DEAD = 4'b0010,
      LS_LIVE = 4'b0100,
      LS_MID = 4'b1000
   } line_state_e;

endpackage : line_state_pkg

// ===== hdl/level_comparator.sv
/*
 one magnitude against a percent threshold of nominal, with hysteresis.
 assumes magnitude, nominal and percent are stable on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module level_comparator
   import line_state_pkg::*;
#(
   parameter int MAG_W_P = MAG_W
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic clear,
   input wire logic [MAG_W_P-1:0] mag,
   input wire logic [MAG_W_P-1:0] nominal,
   input wire logic [PCT_W-1:0] pct,
   output logic over
);
   logic over_q;
   logic over_d;
   wire logic [31:0] magScaled = 32'(mag) * PCT_SCALE;
   wire logic [31:0] pickUp = 32'(nominal) * 32'(pct);
   // cross-multiplied so no divider is needed
   wire logic setCond = magScaled > pickUp; // RULE_03 RULE_04
   wire logic dropCond = (magScaled * HYST_DEN) < (pickUp * HYST_NUM); // RULE_11

   assign over_d = clear ? 1'b0 : (setCond ? 1'b1 : (dropCond ? 1'b0 : over_q)); // RULE_10

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) over_q <= 1'b0;
      else over_q <= over_d;
   end

   assign over = over_q;
endmodule : level_comparator
`default_nettype wire

// ===== hdl/line_state_detector.sv
/*
 dead / live line detector: six hysteresis comparators, decision logic,
 wishbone classic register slave and a level interrupt.
 assumes fundamental magnitudes from the same clock domain; the block
 input is an asynchronous pin and is synchronised here.
*/
// Summary of operation
// RULE_01 - dead status only while all voltages and all currents are below thresholds
// RULE_02 - live status while all three voltages exceed the voltage threshold
// RULE_03 - three per-phase voltage flags, set while voltage above threshold
// RULE_04 - three per-phase current flags, set while current above threshold
// RULE_05 - compare fundamental magnitudes, never raw samples, against thresholds
// RULE_06 - operation setting off or on, off after reset
// RULE_07 - voltage threshold 10 to 100 percent in steps of one, default 60
// RULE_08 - current threshold 2 to 100 percent in steps of one, default 10
// RULE_09 - block input asserted disables the whole function
// RULE_10 - when disabled all flags and both status outputs stay low
// RULE_11 - thresholds are percent of nominal, drop-off at 0.95 of pick-up
`timescale 1ns/1ps
`default_nettype none
module line_state_detector
   import line_state_pkg::*;
#(
   parameter logic [MAG_W-1:0] NOMINAL_VOLTAGE = 16'h4000,
   parameter logic [MAG_W-1:0] NOMINAL_CURRENT = 16'h4000
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire phase_fund_s phaseFund,
   input wire logic blockInput,
   output logic phase1VoltageOver,
   output logic phase2VoltageOver,
   output logic phase3VoltageOver,
   output logic phase1CurrentOver,
   output logic phase2CurrentOver,
   output logic phase3CurrentOver,
   output logic deadLineOutput,
   output logic liveLineOutput,
   output logic irq
);

   function automatic logic [PCT_W-1:0] clampPct(input logic [7:0] v, input logic [PCT_W-1:0] lo,
                                                   input logic [PCT_W-1:0] hi);
      logic [PCT_W-1:0] r;
      r = v[PCT_W-1:0];
      if (v < {1'b0, lo}) r = lo;
      else if (v > {1'b0, hi}) r = hi;
      return r;
   endfunction : clampPct

   // registers
   logic operation_q;
   logic [PCT_W-1:0] voltThr_q;
   logic [PCT_W-1:0] currThr_q;
   logic [IRQ_W-1:0] irqStat_q;
   logic [IRQ_W-1:0] irqStat_d;
   logic [IRQ_W-1:0] irqEn_q;
   logic irq_q;
   logic ack_q;
   logic [31:0] rdData_q;
   logic [31:0] rdData_d;

   // block pin synchroniser
   logic blkSync1_q;
   logic blkSync2_q;
   logic blkSync3_q;
   logic blockActive_q;

   // decision state
   logic compValid_q;
   line_state_e lineState_d;
   logic dead_q;
   logic live_q;

   // bus decode
   wire logic busReq = cyc_i & stb_i & ~ack_q;
   wire logic busWr = busReq & we_i & sel_i[0];
   wire logic wrCtrl = busWr & (adr_i == REG_CTRL);
   wire logic wrVolt = busWr & (adr_i == REG_VOLT_THR);
   wire logic wrCurr = busWr & (adr_i == REG_CURR_THR);
   wire logic wrClr = busWr & (adr_i == REG_IRQ_CLR);
   wire logic wrEn = busWr & (adr_i == REG_IRQ_EN);

   // function enable
   wire logic funcEnabled = operation_q & ~blockActive_q; // RULE_06 RULE_09
   wire logic compClear = ~funcEnabled; // RULE_10

   // comparator array
   wire logic [MAG_W-1:0] voltMag [3];
   wire logic [MAG_W-1:0] currMag [3];
   logic [2:0] voltOver;
   logic [2:0] currOver;

   // only fundamental magnitudes reach the comparators
   assign voltMag[0] = phaseFund.phase1VoltageFundamental; // RULE_05
   assign voltMag[1] = phaseFund.phase2VoltageFundamental; // RULE_05
   assign voltMag[2] = phaseFund.phase3VoltageFundamental; // RULE_05
   assign currMag[0] = phaseFund.phase1CurrentFundamental; // RULE_05
   assign currMag[1] = phaseFund.phase2CurrentFundamental; // RULE_05
   assign currMag[2] = phaseFund.phase3CurrentFundamental; // RULE_05

   for (genvar p = 0; p < 3; p++) begin : g_phase
      level_comparator #(.MAG_W_P(MAG_W)) u_volt (
         .core_clk(core_clk),
         .arst_n(arst_n),
         .clear(compClear),
         .mag(voltMag[p]),
         .nominal(NOMINAL_VOLTAGE),
         .pct(voltThr_q),
         .over(voltOver[p])
      ); // RULE_03 RULE_11
      level_comparator #(.MAG_W_P(MAG_W)) u_curr (
         .core_clk(core_clk),
         .arst_n(arst_n),
         .clear(compClear),
         .mag(currMag[p]),
         .nominal(NOMINAL_CURRENT),
         .pct(currThr_q),
         .over(currOver[p])
      ); // RULE_04 RULE_11
   end

   // decision; cleared comparators read all low for one edge after release,
   // which would look like a dead line, so the decision waits one edge for them
   wire logic flagsValid = funcEnabled & compValid_q; // RULE_01 RULE_10
   wire logic deadCond = flagsValid & ~|voltOver & ~|currOver; // RULE_01 RULE_10
   wire logic liveCond = flagsValid & (&voltOver); // RULE_02 RULE_10

   always_comb begin
      lineState_d = LS_MID;
      case (1'b1)
         !flagsValid: lineState_d = LS_OFF;
         deadCond: lineState_d = LS_DEAD;
         liveCond: lineState_d = LS_LIVE;
         default: lineState_d = LS_MID;
      endcase
   end

   wire logic dead_d = (lineState_d == LS_DEAD);
   wire logic live_d = (lineState_d == LS_LIVE);

   // events: set wins over a clear in the same cycle
   wire logic [IRQ_W-1:0] irqEvents = {live_q & ~live_d, ~live_q & live_d, dead_q & ~dead_d, ~dead_q & dead_d};
   wire logic [IRQ_W-1:0] clrMask = wrClr ? dat_i[IRQ_W-1:0] : '0;
   assign irqStat_d = (irqStat_q & ~clrMask) | irqEvents;
   wire logic irq_d = |(irqStat_d & irqEn_q);

   // read mux, unmapped reads return zero
   wire logic [31:0] flagsWord = {23'h00_0000, blockActive_q, live_q, dead_q, currOver, voltOver};
   always_comb begin
      case (adr_i)
         REG_CTRL: rdData_d = {31'h0000_0000, operation_q};
         REG_VOLT_THR: rdData_d = {25'h000_0000, voltThr_q};
         REG_CURR_THR: rdData_d = {25'h000_0000, currThr_q};
         REG_FLAGS: rdData_d = flagsWord;
         REG_IRQ_STAT: rdData_d = {28'h000_0000, irqStat_q};
         REG_IRQ_EN: rdData_d = {28'h000_0000, irqEn_q};
         default: rdData_d = 32'h0000_0000;
      endcase
   end

   // block pin: a change counts once stages two and three agree
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         blkSync1_q <= 1'b0;
         blkSync2_q <= 1'b0;
         blkSync3_q <= 1'b0;
         blockActive_q <= 1'b0;
      end else begin
         blkSync1_q <= blockInput;
         blkSync2_q <= blkSync1_q;
         blkSync3_q <= blkSync2_q;
         if (blkSync2_q == blkSync3_q) blockActive_q <= blkSync3_q; // RULE_09
      end
   end

   // settings; out-of-range thresholds are clamped, not rejected
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         operation_q <= CTRL_OPERATION_RST; // RULE_06
         voltThr_q <= VOLT_THR_RST; // RULE_07
         currThr_q <= CURR_THR_RST; // RULE_08
         irqEn_q <= '0;
      end else begin
         if (wrCtrl) operation_q <= dat_i[CTRL_OPERATION_BIT]; // RULE_06
         if (wrVolt) voltThr_q <= clampPct(dat_i[7:0], VOLT_THR_MIN, VOLT_THR_MAX); // RULE_07
         if (wrCurr) currThr_q <= clampPct(dat_i[7:0], CURR_THR_MIN, CURR_THR_MAX); // RULE_08
         if (wrEn) irqEn_q <= dat_i[IRQ_W-1:0];
      end
   end

   // decision state and interrupt
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         compValid_q <= 1'b0;
         dead_q <= 1'b0;
         live_q <= 1'b0;
         irqStat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         compValid_q <= funcEnabled; // RULE_01
         dead_q <= dead_d; // RULE_01
         live_q <= live_d; // RULE_02
         irqStat_q <= irqStat_d;
         irq_q <= irq_d;
      end
   end

   // bus answer one cycle after the request is seen
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_q <= 1'b0;
         rdData_q <= 32'h0000_0000;
      end else begin
         ack_q <= busReq;
         if (busReq) rdData_q <= rdData_d;
      end
   end

   assign dat_o = rdData_q;
   assign ack_o = ack_q;
   assign irq = irq_q;
   assign phase1VoltageOver = voltOver[0];
   assign phase2VoltageOver = voltOver[1];
   assign phase3VoltageOver = voltOver[2];
   assign phase1CurrentOver = currOver[0];
   assign phase2CurrentOver = currOver[1];
   assign phase3CurrentOver = currOver[2];
   assign deadLineOutput = dead_q;
   assign liveLineOutput = live_q;

endmodule : line_state_detector
`default_nettype wire

// ===== verif/line_state_chk.sv
/*
 assertions on the ports of line_state_detector.
 assumes a bind from the bench and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module line_state_chk
   import line_state_pkg::*;
#(
   parameter logic [MAG_W-1:0] NOMINAL_VOLTAGE = 16'h4000,
   parameter logic [MAG_W-1:0] NOMINAL_CURRENT = 16'h4000
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire phase_fund_s phaseFund,
   input wire logic blockInput,
   input wire logic phase1VoltageOver,
   input wire logic phase2VoltageOver,
   input wire logic phase3VoltageOver,
   input wire logic phase1CurrentOver,
   input wire logic phase2CurrentOver,
   input wire logic phase3CurrentOver,
   input wire logic deadLineOutput,
   input wire logic liveLineOutput,
   input wire logic irq
);
   wire logic [5:0] flags = {phase1VoltageOver, phase2VoltageOver, phase3VoltageOver,
      phase1CurrentOver, phase2CurrentOver, phase3CurrentOver};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   a_dead_all_low: assert property (deadLineOutput |-> $past(flags) == 6'h00)
      else $error("dead with a flag set");
   a_live_all_volt: assert property (liveLineOutput |-> $past(flags[5:3]) == 3'h7)
      else $error("live without all voltages");
   a_volt_rise_min: assert property ($rose(phase1VoltageOver) |->
      32'($past(phaseFund.phase1VoltageFundamental)) * PCT_SCALE > 32'(NOMINAL_VOLTAGE) * 32'(VOLT_THR_MIN))
      else $error("voltage flag below minimum");
   a_curr_rise_min: assert property ($rose(phase1CurrentOver) |->
      32'($past(phaseFund.phase1CurrentFundamental)) * PCT_SCALE > 32'(NOMINAL_CURRENT) * 32'(CURR_THR_MIN))
      else $error("current flag below minimum");
   a_ack_one_cycle: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acked");
   // sync plus comparator clear plus decision needs five edges
   a_block_quiet: assert property (blockInput [*8] |->
      flags == 6'h00 && !deadLineOutput && !liveLineOutput)
      else $error("outputs active while blocked");
   a_unmapped_zero: assert property (ack_o && $past(!we_i && adr_i > REG_IRQ_EN) |-> dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   c_dead: cover property (deadLineOutput);
   c_live: cover property (liveLineOutput);
   c_irq: cover property ($rose(irq));
endmodule : line_state_chk
`default_nettype wire

// ===== verif/phase_source.sv
/*
 front end model: six percent levels become fundamental magnitudes.
 assumes the design is built with a nominal of 100, so magnitude equals percent.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_source
   import line_state_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [5:0][7:0] pct,
   output var phase_fund_s phaseFund
);
   // registered like a real fourier stage, so results lag one cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         phaseFund <= '0;
      end else begin
         phaseFund <= {8'h00, pct[5], 8'h00, pct[4], 8'h00, pct[3], 8'h00, pct[2], 8'h00, pct[1], 8'h00, pct[0]};
      end
   end
endmodule : phase_source
`default_nettype wire

// ===== verif/tb_line_state_detector.sv
/*
 bench for line_state_detector: table of magnitude rows, then bus,
 interrupt, block and threshold cases.
 assumes the front end model and the checker bound at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_line_state_detector
   import line_state_pkg::*;
;
   typedef struct packed {
      logic [47:0] mags;
      logic [7:0] expOut;
   } row_s;
   // rows run in order: hysteresis makes the expectations of ROWS[2] to ROWS[4] depend on the row before
   localparam row_s ROWS [7] = '{'{48'h0000_0000_0000, 8'h02}, '{48'h3D3D_3D00_0000, 8'hE1},
      '{48'h3C3C_3C0B_0000, 8'hF1}, '{48'h393D_3D0A_0B00, 8'hF9}, '{48'h383D_3D09_0A00, 8'h68},
      '{48'h0000_0000_0000, 8'h02}, '{48'h0000_3D00_000B, 8'h24}};
   logic core_clk = 1'b0, arst_n = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, blockInput = 1'b0;
   logic [ADR_W-1:0] adr_i = '0;
   logic [3:0] sel_i = '0;
   logic [3:0] wrSel = 4'hF;
   logic [31:0] dat_i = '0, dat_o, r;
   logic [5:0][7:0] pct = '0;
   logic ack_o, irq, deadLineOutput, liveLineOutput;
   logic phase1VoltageOver, phase2VoltageOver, phase3VoltageOver;
   logic phase1CurrentOver, phase2CurrentOver, phase3CurrentOver;
   phase_fund_s phaseFund;
   int numErrors = 0;
   int checks = 0;
   wire logic [7:0] outs = {phase1VoltageOver, phase2VoltageOver, phase3VoltageOver, phase1CurrentOver,
      phase2CurrentOver, phase3CurrentOver, deadLineOutput, liveLineOutput};
   always #2 core_clk = ~core_clk;
   phase_source i_src (.*);
   line_state_detector #(.NOMINAL_VOLTAGE(16'h0064), .NOMINAL_CURRENT(16'h0064)) i_dut (.*);
   task automatic chk(input string what, input logic [31:0] expV, input logic [31:0] got);
      checks++;
      if (got !== expV) begin
         $display("Error %s expected %h seen %h", what, expV, got);
         numErrors++;
      end
   endtask : chk
   task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= wrSel;
      // no cycle count assumed: a missing ack is left to the watchdog
      do begin
         @(posedge core_clk);
      end while (ack_o !== 1'b1);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge core_clk);
   endtask : wb
   task automatic tallyAndFinish();
      if (numErrors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tallyAndFinish
   initial begin
      repeat (5000) @(posedge core_clk);
      numErrors++;
      tallyAndFinish();
   end
   initial begin
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      wb(1'b0, REG_CTRL, 0);
      chk("ctrl", 8'h00, r);
      wb(1'b0, REG_VOLT_THR, 0);
      chk("vthr", 8'h3C, r);
      wb(1'b0, REG_CURR_THR, 0);
      chk("cthr", 8'h0A, r);
      repeat (4) @(posedge core_clk);
      chk("off", 8'h00, outs);
      wb(1'b1, REG_CTRL, 1);
      foreach (ROWS[k]) begin
         pct <= ROWS[k].mags;
         repeat (4) @(posedge core_clk);
         chk("row", ROWS[k].expOut, outs);
      end
      wb(1'b1, REG_IRQ_CLR, 15);
      wb(1'b1, REG_IRQ_EN, 4);
      wb(1'b0, REG_IRQ_STAT, 0);
      chk("stat", 8'h00, r);
      pct <= 48'h3D3D_3D00_0000;
      repeat (6) @(posedge core_clk);
      chk("irq", 1'b1, irq);
      wb(1'b0, REG_IRQ_STAT, 0);
      chk("stat", 8'h04, r);
      wb(1'b1, REG_IRQ_EN, 0);
      chk("masked", 1'b0, irq);
      wb(1'b1, REG_IRQ_CLR, 4);
      wb(1'b0, REG_IRQ_STAT, 0);
      chk("clr", 8'h00, r);
      blockInput <= 1'b1;
      repeat (8) @(posedge core_clk);
      chk("blk", 8'h00, outs);
      wb(1'b0, REG_FLAGS, 0);
      chk("flags", 32'h0000_0100, r);
      blockInput <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk("unblk", 8'hE1, outs);
      // live fell and rose again; voltages stayed up, so no dead edge may show
      wb(1'b0, REG_IRQ_STAT, 0);
      chk("stat unblk", 8'h0C, r);
      wb(1'b1, REG_VOLT_THR, 5);
      wb(1'b0, REG_VOLT_THR, 0);
      chk("vmin", 8'h0A, r);
      wb(1'b1, REG_VOLT_THR, 101);
      wb(1'b0, REG_VOLT_THR, 0);
      chk("vmax", 8'h64, r);
      repeat (4) @(posedge core_clk);
      chk("v100", 8'h02, outs);
      wb(1'b1, REG_CURR_THR, 1);
      wb(1'b0, REG_CURR_THR, 0);
      chk("cmin", 8'h02, r);
      pct <= 48'h3D3D_3D03_0303;
      repeat (4) @(posedge core_clk);
      chk("c2", 8'h1C, outs);
      wb(1'b1, REG_CTRL, 0);
      repeat (3) @(posedge core_clk);
      chk("disable", 8'h00, outs);
      wb(1'b0, REG_IRQ_STAT, 0);
      chk("stat all", 8'h0F, r);
      wb(1'b0, 5'h1C, 0);
      chk("unmapped", 8'h00, r);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      chk("rst outs", 8'h00, outs);
      wb(1'b0, REG_VOLT_THR, 0);
      chk("vthr rst", 8'h3C, r);
      wb(1'b0, REG_CURR_THR, 0);
      chk("cthr rst", 8'h0A, r);
      // a write without the low byte lane enabled must leave the register alone
      wrSel = 4'hE;
      wb(1'b1, REG_CTRL, 1);
      wrSel = 4'hF;
      wb(1'b0, REG_CTRL, 0);
      chk("ctrl rst", 8'h00, r);
      tallyAndFinish();
   end
endmodule : tb_line_state_detector
bind line_state_detector line_state_chk #(.NOMINAL_VOLTAGE(NOMINAL_VOLTAGE), .NOMINAL_CURRENT(NOMINAL_CURRENT)) i_chk (.*);
`default_nettype wire
